// File: design/pilc_pkg.sv
// Purpose: Shared constants of the parallel I/O line controller
// Assumes: 32-bit AHB-Lite register bank, one aligned word per register
// Notes:   Addresses are full byte addresses on the system bus
package pilc_pkg;

	// Line count; every register except write protect carries one bit per line
	localparam int          LINES            = 32;

	// Register byte addresses
	localparam logic [31:0] ADDR_OWNER_STAT  = 32'h400e0e08;
	localparam logic [31:0] ADDR_OE_SET      = 32'h400e0e10;
	localparam logic [31:0] ADDR_OE_CLEAR    = 32'h400e0e14;
	localparam logic [31:0] ADDR_OE_STATE    = 32'h400e0e18;
	localparam logic [31:0] ADDR_FILT_ON     = 32'h400e0e20;
	localparam logic [31:0] ADDR_FILT_OFF    = 32'h400e0e24;
	localparam logic [31:0] ADDR_FILT_STATE  = 32'h400e0e28;
	localparam logic [31:0] ADDR_DRV_SET     = 32'h400e0e30;
	localparam logic [31:0] ADDR_DRV_CLEAR   = 32'h400e0e34;
	localparam logic [31:0] ADDR_DRV_STATE   = 32'h400e0e38;
	localparam logic [31:0] ADDR_PIN_SAMPLE  = 32'h400e0e3c;
	localparam logic [31:0] ADDR_IRQ_EN_SET  = 32'h400e0e40;
	localparam logic [31:0] ADDR_DIRECT_WR   = 32'h400e0ea8;
	localparam logic [31:0] ADDR_WR_PROTECT  = 32'h400e0ee4;

	// Field position of the protect enable inside its register
	localparam int          WP_ON_BIT        = 0;

	// Reset values
	localparam logic [31:0] RST_OE           = 32'h00000000;
	localparam logic [31:0] RST_FILT         = 32'h00000000;
	localparam logic [31:0] RST_DRV          = 32'h00000000;
	localparam logic [31:0] RST_IRQ_EN       = 32'h00000000;
	localparam logic [31:0] RST_DIRECT_WR    = 32'h00000000;
	localparam logic        RST_WP           = 1'b0;
	localparam logic [31:0] RST_RDATA        = 32'h00000000;

	// AHB-Lite encodings
	localparam logic [1:0]  HTRANS_IDLE      = 2'h0;
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic        HRESP_OKAY       = 1'b0;

endpackage : pilc_pkg

// File: design/pilc_top.sv
// Purpose: Per-line control and status of a 32-line parallel I/O port, AHB-Lite slave
// Assumes: sys_clk 250 MHz, resetn synchronous active low, pins asynchronous
// Notes:   Zero wait state slave; read data reflects writes of the preceding transfer
//
// What this block does
// (R1) Ownership status reads 1 where the controller owns the line, 0 for peripheral.
// (R2) Output and filter enable/disable writes act only with write protection off.
// (R3) A 1 written to output enable set turns that line's driver on.
// (R4) A 1 written to output enable clear makes that line input only.
// (R5) Output enable state reads 1 for driven lines, 0 for pure inputs.
// (R6) A 1 written to glitch filter on enables that line's input filter.
// (R7) A 1 written to glitch filter off disables that line's input filter.
// (R8) Glitch filter state reads 1 where filter enabled, 0 where disabled.
// (R9) A 1 written to drive value set makes that line's drive value 1.
// (R10) A 1 written to drive value clear makes that line's drive value 0.
// (R11) Drive value state reads the value scheduled to be driven per line.
// (R12) Drive value state is writable only on lines enabled for direct write.
// (R13) Pin level sample reads the sampled logic level of each line.
// (R14) Pin sampling runs only while the controller clock is on, else holds.
// (R15) A 1 written to interrupt enable set enables change interrupt on that line.
// (R16) All registers are 32 bits, bit n serving line n, except write protect (enable in bit 0).
// (R17) A write refused by protection changes nothing and answers OKAY.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
module pilc_top (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Neighbouring logic of the port
	input  wire logic [31:0] lineOwnedByIo,
	input  wire logic        pioClockOn,
	// Pads
	input  wire logic [31:0] pinIn,
	output logic      [31:0] pinOut,
	output logic      [31:0] pinOe,
	// Change interrupt enables for the interrupt logic of the port
	output logic      [31:0] changeIrqEnable
);

	// Register state, one bit per line except the single wpOn bit
	logic [31:0] outEnable;     // R16
	logic [31:0] filtEnable;
	logic [31:0] driveValue;
	logic [31:0] irqEnable;
	logic [31:0] directWrLines;
	logic        wpOn;
	logic [31:0] next_outEnable;
	logic [31:0] next_filtEnable;
	logic [31:0] next_driveValue;
	logic [31:0] next_irqEnable;
	logic [31:0] next_directWrLines;
	logic        next_wpOn;

	// Data phase bookkeeping
	logic        dpWrite;
	logic [31:0] dpAddr;
	logic [31:0] readMux;

	// Pin sampling chain
	logic [31:0] pinMeta;
	logic [31:0] pinSync;
	logic [31:0] pinPrev;
	logic [31:0] pinLevel;
	logic [31:0] next_pinLevel;

	// Address phase acceptance
	wire         apValid  = hsel && hready && (htrans == pilc_pkg::HTRANS_NONSEQ);
	wire         apRead   = apValid && !hwrite;
	wire         apWrite  = apValid && hwrite;

	// Data phase write strobes, one per writable register
	wire         wrOeSet   = dpWrite && (dpAddr == pilc_pkg::ADDR_OE_SET);
	wire         wrOeClr   = dpWrite && (dpAddr == pilc_pkg::ADDR_OE_CLEAR);
	wire         wrFiltOn  = dpWrite && (dpAddr == pilc_pkg::ADDR_FILT_ON);
	wire         wrFiltOff = dpWrite && (dpAddr == pilc_pkg::ADDR_FILT_OFF);
	wire         wrDrvSet  = dpWrite && (dpAddr == pilc_pkg::ADDR_DRV_SET);
	wire         wrDrvClr  = dpWrite && (dpAddr == pilc_pkg::ADDR_DRV_CLEAR);
	wire         wrDrvSt   = dpWrite && (dpAddr == pilc_pkg::ADDR_DRV_STATE);
	wire         wrIrqEn   = dpWrite && (dpAddr == pilc_pkg::ADDR_IRQ_EN_SET);
	wire         wrDirect  = dpWrite && (dpAddr == pilc_pkg::ADDR_DIRECT_WR);
	wire         wrProtect = dpWrite && (dpAddr == pilc_pkg::ADDR_WR_PROTECT);

	// Protection gate; a refused write just falls through, still OKAY
	wire         wrAllowed = !wpOn;                                               // R2 R17
	wire         wrProtHit = wrOeSet || wrOeClr || wrFiltOn || wrFiltOff || wrDirect;

	// Zero wait states, never an error
	assign hreadyout = 1'b1;
	assign hresp     = pilc_pkg::HRESP_OKAY;                                      // R17

	// Capture of the address phase for the following data phase
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dpWrite <= 1'b0;
			dpAddr  <= 32'h00000000;
		end else if (hready) begin
			dpWrite <= apWrite;
			dpAddr  <= haddr;
		end
	end

	// Next register values; set and clear strobes never coincide on one bus
	always_comb begin
		next_outEnable     = outEnable;
		next_filtEnable    = filtEnable;
		next_driveValue    = driveValue;
		next_irqEnable     = irqEnable;
		next_directWrLines = directWrLines;
		next_wpOn          = wpOn;
		if (wrOeSet && wrAllowed) begin
			next_outEnable = outEnable | hwdata;                              // R3 R2
		end else if (wrOeClr && wrAllowed) begin
			next_outEnable = outEnable & ~hwdata;                             // R4 R2
		end
		if (wrFiltOn && wrAllowed) begin
			next_filtEnable = filtEnable | hwdata;                            // R6 R2
		end else if (wrFiltOff && wrAllowed) begin
			next_filtEnable = filtEnable & ~hwdata;                           // R7 R2
		end
		if (wrDrvSet) begin
			next_driveValue = driveValue | hwdata;                            // R9
		end else if (wrDrvClr) begin
			next_driveValue = driveValue & ~hwdata;                           // R10
		end else if (wrDrvSt) begin
			next_driveValue = (driveValue & ~directWrLines) | (hwdata & directWrLines); // R12
		end
		if (wrIrqEn) begin
			next_irqEnable = irqEnable | hwdata;                              // R15
		end
		if (wrDirect && wrAllowed) begin
			next_directWrLines = hwdata;
		end
		if (wrProtect) begin
			next_wpOn = hwdata[pilc_pkg::WP_ON_BIT];
		end
	end

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			outEnable     <= pilc_pkg::RST_OE;
			filtEnable    <= pilc_pkg::RST_FILT;
			driveValue    <= pilc_pkg::RST_DRV;
			irqEnable     <= pilc_pkg::RST_IRQ_EN;
			directWrLines <= pilc_pkg::RST_DIRECT_WR;
			wpOn          <= pilc_pkg::RST_WP;
		end else begin
			outEnable     <= next_outEnable;
			filtEnable    <= next_filtEnable;
			driveValue    <= next_driveValue;
			irqEnable     <= next_irqEnable;
			directWrLines <= next_directWrLines;
			wpOn          <= next_wpOn;
		end
	end

	// Two-stage synchroniser, the first stage only feeds the second
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pinMeta <= 32'h00000000;
			pinSync <= 32'h00000000;
		end else begin
			pinMeta <= pinIn;
			pinSync <= pinMeta;
		end
	end

	// Glitch filter: a filtered line follows only a level stable for two samples
	always_comb begin
		next_pinLevel = pinLevel;
		for (int i = 0; i < pilc_pkg::LINES; i++) begin
			if (!filtEnable[i] || (pinSync[i] == pinPrev[i])) begin
				next_pinLevel[i] = pinSync[i];                            // R13
			end
		end
	end

	// Sampling halts with the controller clock, so the last level is held
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pinPrev  <= 32'h00000000;
			pinLevel <= 32'h00000000;
		end else if (pioClockOn) begin                                            // R14
			pinPrev  <= pinSync;
			pinLevel <= next_pinLevel;
		end
	end

	// Read selection from next values, so a write right before a read is seen
	always_comb begin
		if (haddr == pilc_pkg::ADDR_OWNER_STAT) begin
			readMux = lineOwnedByIo;                                          // R1
		end else if (haddr == pilc_pkg::ADDR_OE_STATE) begin
			readMux = next_outEnable;                                         // R5
		end else if (haddr == pilc_pkg::ADDR_FILT_STATE) begin
			readMux = next_filtEnable;                                        // R8
		end else if (haddr == pilc_pkg::ADDR_DRV_STATE) begin
			readMux = next_driveValue;                                        // R11
		end else if (haddr == pilc_pkg::ADDR_PIN_SAMPLE) begin
			readMux = next_pinLevel & {32{pioClockOn}} | pinLevel & {32{!pioClockOn}}; // R13 R14
		end else if (haddr == pilc_pkg::ADDR_DIRECT_WR) begin
			readMux = next_directWrLines;
		end else if (haddr == pilc_pkg::ADDR_WR_PROTECT) begin
			readMux = {31'h00000000, next_wpOn};
		end else begin
			readMux = 32'h00000000;                                           // Write-only or unmapped
		end
	end

	// Read data register, loaded at the end of a read address phase
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hrdata <= pilc_pkg::RST_RDATA;
		end else if (apRead) begin
			hrdata <= readMux;
		end
	end

	// Pad drive; a line owned by a peripheral is not driven from here
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pinOut          <= pilc_pkg::RST_DRV;
			pinOe           <= pilc_pkg::RST_OE;
			changeIrqEnable <= pilc_pkg::RST_IRQ_EN;
		end else begin
			pinOut          <= driveValue;
			pinOe           <= outEnable & lineOwnedByIo;                     // R1 R3 R4
			changeIrqEnable <= irqEnable;                                     // R15
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic        rdPhase;
	logic [31:0] rdAddr;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rdPhase <= 1'b0;
			rdAddr  <= 32'h00000000;
		end else if (hready) begin
			rdPhase <= apRead;
			rdAddr  <= haddr;
		end
	end

	sequence sOeSetOk;
		wrOeSet && !wpOn;
	endsequence
	sequence sProtWrite;
		wrProtHit && wpOn;
	endsequence
	sequence sOeClrOk;
		wrOeClr && !wpOn;
	endsequence

	AST_OE_SET: assert property (sOeSetOk |=> ((outEnable & $past(hwdata)) == $past(hwdata))
		&& ((outEnable & ~$past(hwdata)) == ($past(outEnable) & ~$past(hwdata))))      // R3
		else $error("output enable set failed");
	AST_OE_CLR: assert property (wrOeClr && !wpOn |=> (outEnable == ($past(outEnable) & ~$past(hwdata)))) // R4
		else $error("output enable clear failed");
	AST_WP_BLOCK: assert property (sProtWrite |=> $stable(outEnable) && $stable(filtEnable)
		&& $stable(directWrLines))                                              // R2
		else $error("protected write changed state");
	AST_FILT_ON: assert property (wrFiltOn && !wpOn |=> (filtEnable == ($past(filtEnable) | $past(hwdata)))) // R6
		else $error("filter enable failed");
	AST_FILT_OFF: assert property (wrFiltOff && !wpOn |=> (filtEnable == ($past(filtEnable) & ~$past(hwdata)))) // R7
		else $error("filter disable failed");
	AST_DRV_SET: assert property (wrDrvSet |=> (driveValue == ($past(driveValue) | $past(hwdata))) ##1
		(pinOut == $past(driveValue)))                                          // R9
		else $error("drive set failed");
	AST_DRV_CLR: assert property (wrDrvClr |=> (driveValue == ($past(driveValue) & ~$past(hwdata)))) // R10
		else $error("drive clear failed");
	AST_DRV_DIRECT: assert property (wrDrvSt |=> ((driveValue ^ $past(driveValue)) & ~$past(directWrLines))
		== 32'h00000000)                                                        // R12
		else $error("drive write hit locked line");
	AST_OE_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_OE_STATE) |-> (hrdata == outEnable)) // R5
		else $error("output state read wrong");
	AST_FILT_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_FILT_STATE) |-> (hrdata == filtEnable)) // R8
		else $error("filter state read wrong");
	AST_DRV_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_DRV_STATE) |-> (hrdata == driveValue)) // R11
		else $error("drive state read wrong");
	AST_PIN_HOLD: assert property (!pioClockOn |=> $stable(pinLevel))         // R14
		else $error("pin level moved with clock off");
	AST_PIN_TRACK: assert property (pioClockOn && (filtEnable == 32'h00000000) |=> (pinLevel == $past(pinSync))) // R13
		else $error("pin level not sampled");
	AST_IRQ_EN: assert property (wrIrqEn |=> ##1 ((changeIrqEnable & $past(hwdata, 2)) == $past(hwdata, 2))) // R15
		else $error("irq enable not set");
	AST_OKAY: assert property (hreadyout && (hresp == pilc_pkg::HRESP_OKAY)) // R17
		else $error("bus answer not OKAY");

	// Pad enable only where the controller owns the line
	AST_PAD_OWNER: assert property (1'b1 |=> (pinOe == ($past(outEnable) & $past(lineOwnedByIo)))) // R1
		else $error("pad enable ignores ownership");

	// Pad drive trails the stored drive value by one edge
	AST_PAD_DRIVE: assert property (1'b1 |=> (pinOut == $past(driveValue))) // R11
		else $error("pad drive not following drive value");

	// Interrupt enable output trails its register by one edge
	AST_IRQ_FOLLOW: assert property (1'b1 |=> (changeIrqEnable == $past(irqEnable))) // R15
		else $error("interrupt enable output lags wrongly");

	// Set only: no enable bit ever drops while running
	AST_IRQ_STICKY: assert property (1'b1 |=> ((irqEnable & $past(irqEnable)) == $past(irqEnable))) // R15
		else $error("interrupt enable bit dropped");

	// Without its strobe the interrupt enable holds
	AST_IRQ_NOCLR: assert property (!wrIrqEn |=> $stable(irqEnable)) // R15
		else $error("interrupt enable moved without write");

	// Output enable moves only on its own two strobes
	AST_OE_LOCK: assert property (!wrOeSet && !wrOeClr |=> $stable(outEnable)) // R3 R4
		else $error("output enable moved without write");

	// Filter enable moves only on its own two strobes
	AST_FILT_LOCK: assert property (!wrFiltOn && !wrFiltOff |=> $stable(filtEnable)) // R8
		else $error("filter enable moved without write");

	// Drive value moves only on set, clear or direct write
	AST_DRV_LOCK: assert property (!wrDrvSet && !wrDrvClr && !wrDrvSt |=> $stable(driveValue)) // R11
		else $error("drive value moved without write");

	// Enabled lines take the written data on a direct write
	AST_DRV_ST_WRITE: assert property (wrDrvSt |=> (((driveValue ^ $past(hwdata)) & $past(directWrLines)) == 32'h00000000)) // R12
		else $error("direct write missed an enabled line");

	// Direct write mask replaced whole when unprotected
	AST_DIRECT_SET: assert property (wrDirect && !wpOn |=> (directWrLines == $past(hwdata))) // R12
		else $error("direct write mask not loaded");

	// Cleared lines reach the pad two edges after the data phase
	AST_DRV_CLR_PAD: assert property (wrDrvClr |=> ##1 ((pinOut & $past(hwdata, 2)) == 32'h00000000)) // R10
		else $error("cleared line still driven high");

	// Disabled lines stop driving two edges after the data phase
	AST_OE_PAD: assert property (sOeClrOk |=> ##1 ((pinOe & $past(hwdata, 2)) == 32'h00000000)) // R4
		else $error("disabled line still driven");

	// Protect bit loads from bit zero of the written word
	AST_WP_SET: assert property (wrProtect |=> ({31'h00000000, wpOn} == ($past(hwdata) & 32'h00000001))) // R2
		else $error("protect bit not loaded");

	// Read-back of the ownership input
	AST_OWNER_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_OWNER_STAT) |-> (hrdata == $past(lineOwnedByIo))) // R1
		else $error("ownership read wrong");

	// Pin sample read matches the level held after the edge
	AST_PIN_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_PIN_SAMPLE) |-> (hrdata == pinLevel)) // R13
		else $error("pin sample read wrong");

	// Write-only output enable set register reads as zero
	AST_WO_READ: assert property (rdPhase && (rdAddr == pilc_pkg::ADDR_OE_SET) |-> (hrdata == 32'h00000000)) // R16
		else $error("write-only register read nonzero");

	// Read data stands until the next read is taken
	AST_RD_HOLD: assert property (!apRead |=> $stable(hrdata)) // R16
		else $error("read data changed without read");

	// Address capture follows every accepted bus cycle
	AST_DP_ADDR: assert property (hready |=> (dpAddr == $past(haddr))) // R16
		else $error("data phase address not captured");

	// Unfiltered lines follow the synchronised level
	AST_PIN_UNFILT: assert property (pioClockOn |=> (((pinLevel ^ $past(pinSync)) & ~$past(filtEnable)) == 32'h00000000)) // R13
		else $error("unfiltered line not sampled");

	// A filtered line ignores a level seen only once
	AST_PIN_GLITCH: assert property (pioClockOn |=> (((pinLevel ^ $past(pinLevel)) & $past(filtEnable)
		& ($past(pinSync) ^ $past(pinPrev))) == 32'h00000000))              // R6
		else $error("filter passed a one sample glitch");

	// Filter history freezes with the controller clock
	AST_PREV_HOLD: assert property (!pioClockOn |=> $stable(pinPrev)) // R14
		else $error("filter history moved with clock off");

endmodule : pilc_top

// File: verif/pilc_pad_model.sv
// Purpose: Pad model for the 32 parallel I/O lines
// Assumes: A driven line reads back its own drive value
// Notes:   Undriven lines take the outside level set by the bench
module pilc_pad_model (
	input  wire logic [31:0] pinOut,
	input  wire logic [31:0] pinOe,
	input  wire logic [31:0] extLevel,
	output logic      [31:0] pinIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// Controller drive wins where enabled, outside level elsewhere
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pilc_pad_model

// File: verif/tb.sv
// Purpose: Self-checking bench of the line controller
// Assumes: Zero wait state slave, hready tied to hreadyout
// Notes:   Expected values are worked out from written patterns
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk;
	logic        resetn;
	logic        hsel;
	logic        hwrite;
	logic        pioClockOn;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] lineOwnedByIo;
	logic [31:0] extLevel;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire  [31:0] pinIn;
	wire  [31:0] pinOut;
	wire  [31:0] pinOe;
	wire  [31:0] changeIrqEnable;
	wire         hreadyout;
	wire         hresp;
	int          n_errors;
	int          cmp_count;
	int          cycles;

	pilc_top i_pilc_top (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .lineOwnedByIo(lineOwnedByIo), .pioClockOn(pioClockOn),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .changeIrqEnable(changeIrqEnable));
	pilc_pad_model i_pilc_pad_model (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

	// Free running clock, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// Hang guard, far above the some 110 cycles needed
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; entered just after a rising edge
	task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] data);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		hsize <= 3'h2;
		htrans <= pilc_pkg::HTRANS_NONSEQ;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= pilc_pkg::HTRANS_IDLE;
		hwdata <= data;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, {31'h0, pilc_pkg::HRESP_OKAY});
	endtask : xfer

	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		xfer(addr, 1'b1, data);
	endtask : wr

	task automatic rdChk(input logic [31:0] addr, input logic [31:0] exp);
		xfer(addr, 1'b0, 32'h00000000);
		chk(rd, exp);
	endtask : rdChk

	// Pad outputs follow a register one edge after it updates
	task automatic settle;
		repeat (2) @(posedge sys_clk);
	endtask : settle

	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = pilc_pkg::HTRANS_IDLE;
		hsize = 3'h2;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		lineOwnedByIo = 32'hffff0000;
		extLevel = 32'h0f0f0f0f;
		pioClockOn = 1'b1;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rdChk(pilc_pkg::ADDR_OE_STATE, pilc_pkg::RST_OE);
		rdChk(pilc_pkg::ADDR_FILT_STATE, pilc_pkg::RST_FILT);
		rdChk(pilc_pkg::ADDR_DRV_STATE, pilc_pkg::RST_DRV);
		rdChk(pilc_pkg::ADDR_OE_SET, 32'h00000000);
		rdChk(32'h400e0e50, 32'h00000000);
		rdChk(pilc_pkg::ADDR_OWNER_STAT, 32'hffff0000);
		$display("Test reset values done");
		wr(pilc_pkg::ADDR_OE_SET, 32'hf0f000ff);
		wr(pilc_pkg::ADDR_OE_CLEAR, 32'h0000000f);
		rdChk(pilc_pkg::ADDR_OE_STATE, 32'hf0f000f0);
		settle();
		chk(pinOe, 32'hf0f00000);
		lineOwnedByIo <= 32'hffffffff;
		settle();
		chk(pinOe, 32'hf0f000f0);
		wr(pilc_pkg::ADDR_FILT_ON, 32'h0000ffff);
		wr(pilc_pkg::ADDR_FILT_OFF, 32'h000000ff);
		rdChk(pilc_pkg::ADDR_FILT_STATE, 32'h0000ff00);
		wr(pilc_pkg::ADDR_DRV_SET, 32'h12345678);
		wr(pilc_pkg::ADDR_DRV_CLEAR, 32'h00000078);
		rdChk(pilc_pkg::ADDR_DRV_STATE, 32'h12345600);
		settle();
		chk(pinOut, 32'h12345600);
		$display("Test set and clear done");
		// Protected writes must leave output enable, filter and direct write settings alone
		wr(pilc_pkg::ADDR_WR_PROTECT, 32'h00000001);
		wr(pilc_pkg::ADDR_OE_SET, 32'hffffffff);
		wr(pilc_pkg::ADDR_OE_CLEAR, 32'hf0000000);
		wr(pilc_pkg::ADDR_FILT_ON, 32'hffffffff);
		wr(pilc_pkg::ADDR_FILT_OFF, 32'h0000ff00);
		wr(pilc_pkg::ADDR_DIRECT_WR, 32'hffffffff);
		rdChk(pilc_pkg::ADDR_OE_STATE, 32'hf0f000f0);
		rdChk(pilc_pkg::ADDR_FILT_STATE, 32'h0000ff00);
		rdChk(pilc_pkg::ADDR_DIRECT_WR, 32'h00000000);
		wr(pilc_pkg::ADDR_DRV_SET, 32'h00000001);
		wr(pilc_pkg::ADDR_WR_PROTECT, 32'h00000000);
		rdChk(pilc_pkg::ADDR_DRV_STATE, 32'h12345601);
		$display("Test protection done");
		wr(pilc_pkg::ADDR_DRV_STATE, 32'hffffffff);
		rdChk(pilc_pkg::ADDR_DRV_STATE, 32'h12345601);
		wr(pilc_pkg::ADDR_DIRECT_WR, 32'h0000ffff);
		wr(pilc_pkg::ADDR_DRV_STATE, 32'ha5a5a5a5);
		rdChk(pilc_pkg::ADDR_DRV_STATE, 32'h1234a5a5);
		$display("Test direct write done");
		// Driven lines read back drive value, others the outside level
		repeat (8) @(posedge sys_clk);
		rdChk(pilc_pkg::ADDR_PIN_SAMPLE, (32'hf0f000f0 & 32'h1234a5a5) | (~32'hf0f000f0 & 32'h0f0f0f0f));
		pioClockOn <= 1'b0;
		extLevel <= 32'h00000000;
		repeat (8) @(posedge sys_clk);
		rdChk(pilc_pkg::ADDR_PIN_SAMPLE, (32'hf0f000f0 & 32'h1234a5a5) | (~32'hf0f000f0 & 32'h0f0f0f0f));
		pioClockOn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rdChk(pilc_pkg::ADDR_PIN_SAMPLE, 32'hf0f000f0 & 32'h1234a5a5);
		$display("Test pin sampling done");
		wr(pilc_pkg::ADDR_IRQ_EN_SET, 32'h80000001);
		wr(pilc_pkg::ADDR_IRQ_EN_SET, 32'h00000100);
		settle();
		chk(changeIrqEnable, 32'h80000101);
		$display("Test interrupt enable done");
		close_out();
	end
endmodule : tb
